// *** hw/tc_pkg.sv ***
// Constants and types shared by the timer compare/capture/quadrature block
package tc_pkg;

	localparam int NCH         = 3;
	localparam int CW          = 16;
	localparam int FILTER_HOLD = 5;

	typedef enum logic [1:0] {CNT_UP, CNT_DOWN, CNT_UPDOWN, CNT_QUAD} count_mode_e;
	typedef enum logic [1:0] {CH_OFF, CH_CAPTURE, CH_COMPARE, CH_PWM} ch_mode_e;

	localparam logic [1:0] ACT_NONE   = 2'h0;
	localparam logic [1:0] ACT_SET    = 2'h1;
	localparam logic [1:0] ACT_CLEAR  = 2'h2;
	localparam logic [1:0] ACT_TOGGLE = 2'h3;

	localparam logic [1:0] EDGE_RISE = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h2;

	////////////////////////////////////////////////////////////////////////////
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_CMD     = 8'h04;
	localparam logic [7:0] ADDR_STATUS  = 8'h08;
	localparam logic [7:0] ADDR_FLAGS   = 8'h0C;
	localparam logic [7:0] ADDR_TOP     = 8'h10;
	localparam logic [7:0] ADDR_CNT     = 8'h14;
	localparam logic [3:0] CH_BASE_HI   = 4'h2;
	localparam logic [3:0] CH_CTRL      = 4'h0;
	localparam logic [3:0] CH_VALUE     = 4'h4;
	localparam logic [3:0] CH_BUFFER    = 4'h8;
	localparam logic [3:0] CH_PEEK      = 4'hC;

	localparam int CTRL_MODE    = 0;
	localparam int CTRL_QDM     = 2;
	localparam int CTRL_ATI     = 3;
	localparam int CTRL_RSS     = 4;
	localparam int CMD_START    = 0;
	localparam int CMD_STOP     = 1;
	localparam int CMD_RELOAD   = 2;
	localparam int ST_RUN       = 0;
	localparam int ST_DIR       = 1;
	localparam int ST_BV        = 2;
	localparam int ST_CV        = 5;
	localparam int ST_POL       = 8;
	localparam int CC_MODE      = 0;
	localparam int CC_INIT      = 2;
	localparam int CC_INV       = 3;
	localparam int CC_MOA       = 4;
	localparam int CC_OFA       = 6;
	localparam int CC_UFA       = 8;
	localparam int CC_FILT      = 10;
	localparam int CC_EDGE      = 11;
	localparam int CC_SRC       = 13;

	localparam logic [CW-1:0] TOP_RESET = 16'hFFFF;

endpackage

// *** hw/timer_capture_compare_quadrature.sv ***
// Timer compare/capture channels with quadrature decoder and APB registers
//
// The register addresses and the APB register port were chosen for this implementation.
module timer_capture_compare_quadrature
	import tc_pkg::*;
(
	input  wire logic              MCLK,
	input  wire logic              RSTN,
	input  wire logic              CE,
	input  wire logic              PSEL,
	input  wire logic              PENABLE,
	input  wire logic              PWRITE,
	input  wire logic [7:0]        PADDR,
	input  wire logic [31:0]       PWDATA,
	output logic      [31:0]       PRDATA,
	output logic                   PREADY,
	output logic                   PSLVERR,
	input  wire logic [NCH-1:0]    CC_PIN,
	input  wire logic [NCH-1:0]    CC_EVT,
	output logic      [NCH-1:0]    CC_OUT
);

	count_mode_e     cmode;
	logic            qdm_x4;
	logic            always_track_inputs;
	logic            rss;
	logic [CW-1:0]   top;
	logic [CW-1:0]   cnt;
	logic [CW-1:0]   next_cnt;
	logic            running;
	logic            dir;
	logic            next_dir;
	logic            stepping;
	logic            going_up;
	logic            ovf;
	logic            unf;
	logic            upd;
	logic            q_inc;
	logic            q_dec;
	logic            a_ed;
	logic            b_ed;

	ch_mode_e        ch_mode  [NCH];
	logic [1:0]      moa      [NCH];
	logic [1:0]      ofa      [NCH];
	logic [1:0]      ufa      [NCH];
	logic [1:0]      edge_sel [NCH];
	logic [2:0]      fcnt     [NCH];
	logic [CW-1:0]   val      [NCH];
	logic [CW-1:0]   buff     [NCH];
	logic [NCH-1:0]  init_st;
	logic [NCH-1:0]  inv;
	logic [NCH-1:0]  filt_en;
	logic [NCH-1:0]  src_sel;
	logic [NCH-1:0]  raw;
	logic [NCH-1:0]  filt;
	logic [NCH-1:0]  ch_in;
	logic [NCH-1:0]  prev_in;
	logic [NCH-1:0]  rise;
	logic [NCH-1:0]  fall;
	logic [NCH-1:0]  hit;
	logic [NCH-1:0]  match;
	logic [NCH-1:0]  pop;
	logic [NCH-1:0]  cap_full;
	logic [NCH-1:0]  cv;
	logic [NCH-1:0]  bv;
	logic [NCH-1:0]  pol;
	logic [NCH-1:0]  ovf_flag;
	logic [NCH-1:0]  ostate;
	logic [NCH-1:0]  next_out;
	logic [NCH-1:0]  wr_ctrl;
	logic [NCH-1:0]  wr_val;
	logic [NCH-1:0]  wr_buf;

	logic            acc;
	logic            done;
	logic            wr;
	logic            is_ch;
	logic [3:0]      ch_off;
	logic [1:0]      ch_idx;
	logic            mapped;
	logic [31:0]     rdata;
	logic            cmd_reload;

	function automatic logic apply_act(input logic [1:0] act, input logic cur);
		case (act)
			ACT_SET:    apply_act = 1'b1;
			ACT_CLEAR:  apply_act = 1'b0;
			ACT_TOGGLE: apply_act = ~cur;
			default:    apply_act = cur;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// APB decode: one wait state, so with CE high every access completes on the second cycle of its access phase
	always_comb begin
		ch_off = PADDR[7:4] - CH_BASE_HI;
		ch_idx = ch_off[1:0];
		is_ch  = (PADDR[7:4] >= CH_BASE_HI) && (ch_off < 4'(NCH)) && (PADDR[1:0] == 2'h0);
		mapped = is_ch || (PADDR[1:0] == 2'h0 && PADDR <= ADDR_CNT);
		acc    = PSEL && PENABLE && !PREADY;
		done   = PSEL && PENABLE && PREADY;
		wr     = done && PWRITE && !PSLVERR;
		cmd_reload = wr && PADDR == ADDR_CMD && PWDATA[CMD_RELOAD];
		for (int i = 0; i < NCH; i++) begin
			wr_ctrl[i] = wr && is_ch && ch_idx == 2'(i) && PADDR[3:0] == CH_CTRL;
			wr_val[i]  = wr && is_ch && ch_idx == 2'(i) && PADDR[3:0] == CH_VALUE;
			wr_buf[i]  = wr && is_ch && ch_idx == 2'(i) && PADDR[3:0] == CH_BUFFER;
			pop[i]     = done && !PWRITE && !PSLVERR && is_ch && ch_idx == 2'(i) &&
				PADDR[3:0] == CH_VALUE && ch_mode[i] == CH_CAPTURE;
		end
	end

	always_comb begin
		rdata = '0;
		if (is_ch) begin
			case (PADDR[3:0])
				CH_CTRL: begin
					rdata[CC_MODE +: 2] = ch_mode[ch_idx];
					rdata[CC_INIT]      = init_st[ch_idx];
					rdata[CC_INV]       = inv[ch_idx];
					rdata[CC_MOA +: 2]  = moa[ch_idx];
					rdata[CC_OFA +: 2]  = ofa[ch_idx];
					rdata[CC_UFA +: 2]  = ufa[ch_idx];
					rdata[CC_FILT]      = filt_en[ch_idx];
					rdata[CC_EDGE +: 2] = edge_sel[ch_idx];
					rdata[CC_SRC]       = src_sel[ch_idx];
				end
				CH_BUFFER: rdata[CW-1:0] = buff[ch_idx];
				default:   rdata[CW-1:0] = val[ch_idx];
			endcase
		end else begin
			case (PADDR)
				ADDR_CTRL: begin
					rdata[CTRL_MODE +: 2] = cmode;
					rdata[CTRL_QDM]       = qdm_x4;
					rdata[CTRL_ATI]       = always_track_inputs;
					rdata[CTRL_RSS]       = rss;
				end
				ADDR_STATUS: begin
					rdata[ST_RUN]        = running;
					rdata[ST_DIR]        = dir;
					rdata[ST_BV +: NCH]  = bv;
					rdata[ST_CV +: NCH]  = cv;
					rdata[ST_POL +: NCH] = pol;
				end
				ADDR_FLAGS: rdata[NCH-1:0] = ovf_flag;
				ADDR_TOP:   rdata[CW-1:0]  = top;
				ADDR_CNT:   rdata[CW-1:0]  = cnt;
				default:    rdata = '0;
			endcase
		end
	end

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h00000000;
		end else if (CE) begin
			PREADY  <= acc;
			PSLVERR <= acc && !mapped;
			PRDATA  <= (acc && !PWRITE) ? rdata : 32'h00000000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Configuration registers
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			cmode  <= CNT_UP;
			qdm_x4 <= 1'b0;
			always_track_inputs    <= 1'b0;
			rss    <= 1'b0;
			top    <= TOP_RESET;
		end else if (CE) begin
			if (wr && PADDR == ADDR_CTRL) begin
				cmode  <= count_mode_e'(PWDATA[CTRL_MODE +: 2]);
				qdm_x4 <= PWDATA[CTRL_QDM];
				always_track_inputs    <= PWDATA[CTRL_ATI];
				rss    <= PWDATA[CTRL_RSS];
			end
			if (wr && PADDR == ADDR_TOP)
				top <= PWDATA[CW-1:0];
		end
	end

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			for (int i = 0; i < NCH; i++) begin
				ch_mode[i]  <= CH_OFF;
				moa[i]      <= ACT_NONE;
				ofa[i]      <= ACT_NONE;
				ufa[i]      <= ACT_NONE;
				edge_sel[i] <= EDGE_RISE;
			end
			init_st <= '0;
			inv     <= '0;
			filt_en <= '0;
			src_sel <= '0;
		end else if (CE) begin
			for (int i = 0; i < NCH; i++) begin
				if (wr_ctrl[i]) begin
					ch_mode[i]  <= ch_mode_e'(PWDATA[CC_MODE +: 2]);
					init_st[i]  <= PWDATA[CC_INIT];
					inv[i]      <= PWDATA[CC_INV];
					moa[i]      <= PWDATA[CC_MOA +: 2];
					ofa[i]      <= PWDATA[CC_OFA +: 2];
					ufa[i]      <= PWDATA[CC_UFA +: 2];
					filt_en[i]  <= PWDATA[CC_FILT];
					edge_sel[i] <= PWDATA[CC_EDGE +: 2];
					src_sel[i]  <= PWDATA[CC_SRC];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Input selection, filter and edge detection
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			raw[i]   = src_sel[i] ? CC_EVT[i] : CC_PIN[i];
			ch_in[i] = filt_en[i] ? filt[i] : raw[i];
			rise[i]  = ch_in[i] && !prev_in[i];
			fall[i]  = !ch_in[i] && prev_in[i];
			hit[i]   = ch_mode[i] == CH_CAPTURE &&
				((edge_sel[i] == EDGE_RISE && rise[i]) ||
				 (edge_sel[i] == EDGE_FALL && fall[i]) ||
				 (edge_sel[i] == EDGE_BOTH && (rise[i] || fall[i])));
			match[i] = (ch_mode[i] == CH_COMPARE || ch_mode[i] == CH_PWM) &&
				val[i] == cnt;
			cap_full[i] = hit[i] && cv[i] && bv[i] && !pop[i];
		end
	end

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			filt    <= '0;
			prev_in <= '0;
			for (int i = 0; i < NCH; i++)
				fcnt[i] <= 3'h0;
		end else if (CE) begin
			prev_in <= ch_in;
			for (int i = 0; i < NCH; i++) begin
				if (raw[i] == filt[i])
					fcnt[i] <= 3'h0;
				else if (fcnt[i] == 3'(FILTER_HOLD - 1)) begin
					filt[i] <= raw[i];
					fcnt[i] <= 3'h0;
				end else
					fcnt[i] <= fcnt[i] + 3'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Quadrature decode and counter; simultaneous A and B edges are ignored
	always_comb begin
		a_ed  = ch_in[0] ^ prev_in[0];
		b_ed  = ch_in[1] ^ prev_in[1];
		q_inc = (a_ed && !b_ed && (ch_in[0] ^ ch_in[1])) ||
			(qdm_x4 && b_ed && !a_ed && !(ch_in[0] ^ ch_in[1]));
		q_dec = (a_ed && !b_ed && !(ch_in[0] ^ ch_in[1])) ||
			(qdm_x4 && b_ed && !a_ed && (ch_in[0] ^ ch_in[1]));
		stepping = running && (cmode != CNT_QUAD || q_inc || q_dec);
		case (cmode)
			CNT_UP:   going_up = 1'b1;
			CNT_DOWN: going_up = 1'b0;
			CNT_QUAD: going_up = q_inc;
			default:  going_up = dir;
		endcase
		ovf = stepping && going_up && cnt == top;
		unf = stepping && !going_up && cnt == '0;
		case (cmode)
			CNT_UP:  upd = ovf;
			CNT_QUAD: upd = ovf || unf;
			default: upd = unf;
		endcase
		next_dir = going_up;
		if (cmode == CNT_UPDOWN)
			next_dir = ovf ? 1'b0 : (unf ? 1'b1 : dir);
		if (!stepping)
			next_cnt = cnt;
		else if (ovf)
			next_cnt = (cmode == CNT_UPDOWN) ? top - 16'h0001 : 16'h0000;
		else if (unf)
			next_cnt = (cmode == CNT_UPDOWN) ? 16'h0001 : top;
		else
			next_cnt = going_up ? cnt + 16'h0001 : cnt - 16'h0001;
	end

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			cnt     <= 16'h0000;
			running <= 1'b0;
			dir     <= 1'b1;
		end else if (CE) begin
			if (cmd_reload)
				cnt <= (cmode == CNT_DOWN) ? top : 16'h0000;
			else if (wr && PADDR == ADDR_CNT)
				cnt <= PWDATA[CW-1:0];
			else
				cnt <= next_cnt;
			if (wr && PADDR == ADDR_CNT)
				dir <= 1'b1;
			else if (stepping)
				dir <= next_dir;
			if (cmd_reload || (wr && PADDR == ADDR_CMD && PWDATA[CMD_START]))
				running <= 1'b1;
			else if (wr && PADDR == ADDR_CMD && PWDATA[CMD_STOP])
				running <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Channel value queue and compare buffer
	always_ff @(posedge MCLK or negedge RSTN) begin
		logic          cv_n;
		logic          bv_n;
		logic [CW-1:0] val_n;
		if (!RSTN) begin
			cv <= '0;
			bv <= '0;
			for (int i = 0; i < NCH; i++) begin
				val[i]  <= 16'h0000;
				buff[i] <= 16'h0000;
			end
		end else if (CE) begin
			for (int i = 0; i < NCH; i++) begin
				if (ch_mode[i] == CH_CAPTURE) begin
					cv_n  = pop[i] ? bv[i] : cv[i];
					bv_n  = pop[i] ? 1'b0 : bv[i];
					val_n = (pop[i] && bv[i]) ? buff[i] : val[i];
					if (hit[i] && !cv_n) begin
						val_n = cnt;
						cv_n  = 1'b1;
					end else if (hit[i]) begin
						buff[i] <= cnt;
						bv_n    = 1'b1;
					end
					val[i] <= val_n;
					cv[i]  <= cv_n;
					bv[i]  <= bv_n;
				end else begin
					cv[i] <= 1'b0;
					if (wr_buf[i] || (wr_val[i] && ch_mode[i] == CH_PWM)) begin
						buff[i] <= PWDATA[CW-1:0];
						bv[i]   <= 1'b1;
					end else if (upd && bv[i]) begin
						bv[i] <= 1'b0;
					end
					if (wr_val[i] && ch_mode[i] == CH_COMPARE)
						val[i] <= PWDATA[CW-1:0];
					else if (upd && bv[i])
						val[i] <= buff[i];
				end
			end
		end
	end

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN)
			ovf_flag <= '0;
		else if (CE)
			ovf_flag <= (ovf_flag & ~((wr && PADDR == ADDR_FLAGS) ? PWDATA[NCH-1:0] : '0))
				| (cap_full & {NCH{running}});
	end

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN)
			pol <= '0;
		else if (CE) begin
			for (int i = 0; i < NCH; i++) begin
				if (always_track_inputs)
					pol[i] <= ch_in[i];
				else if (hit[i])
					pol[i] <= rise[i];
				else if (match[i])
					pol[i] <= ch_in[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output logic; CC_OUT is a flop, so it trails the counter by one clock
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			next_out[i] = ostate[i];
			if (ch_mode[i] == CH_OFF || (cmd_reload && rss))
				next_out[i] = init_st[i];
			else if (ch_mode[i] == CH_COMPARE) begin
				if (match[i])
					next_out[i] = apply_act(moa[i], ostate[i]);
				else if (ovf)
					next_out[i] = apply_act(ofa[i], ostate[i]);
				else if (unf)
					next_out[i] = apply_act(ufa[i], ostate[i]);
			end else if (ch_mode[i] == CH_PWM && (cmode == CNT_UP || cmode == CNT_UPDOWN))
				next_out[i] = cnt < val[i];
		end
	end

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			ostate <= '0;
			CC_OUT <= '0;
		end else if (CE) begin
			ostate <= next_out;
			CC_OUT <= next_out ^ inv;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RSTN);

	sequence s_held;
		(CE && filt_en[0] && raw[0] != filt[0])[*5];
	endsequence
	property p_filter;
		s_held |=> filt[0] == $past(raw[0]);
	endproperty
	a_filter: assert property (p_filter) else $error("filter did not pass level");

	property p_capture;
		CE && hit[0] && !cv[0] && !pop[0] && !always_track_inputs |=> val[0] == $past(cnt) && cv[0]
			&& pol[0] == $past(rise[0]);
	endproperty
	a_capture: assert property (p_capture) else $error("capture value wrong");

	property p_qovf;
		CE && running && cap_full[0] |=> ovf_flag[0] && val[0] == $past(val[0])
			&& buff[0] == $past(cnt);
	endproperty
	a_qovf: assert property (p_qovf) else $error("queue overflow wrong");

	property p_pop;
		CE && pop[0] && !bv[0] && !hit[0] |=> !cv[0];
	endproperty
	a_pop: assert property (p_pop) else $error("valid flag not cleared");

	property p_prio;
		CE && ch_mode[0] == CH_COMPARE && match[0] && ovf && moa[0] == ACT_SET
			&& ofa[0] == ACT_CLEAR && !(cmd_reload && rss) |=> ostate[0];
	endproperty
	a_prio: assert property (p_prio) else $error("overflow beat match");

	property p_inv;
		CE |=> CC_OUT[1] == (ostate[1] ^ $past(inv[1]));
	endproperty
	a_inv: assert property (p_inv) else $error("output inversion wrong");

	property p_bufmove;
		CE && upd && bv[0] && ch_mode[0] == CH_COMPARE && !wr_buf[0] && !wr_val[0]
			|=> val[0] == $past(buff[0]) && !bv[0];
	endproperty
	a_bufmove: assert property (p_bufmove) else $error("buffer not applied");

	property p_x2;
		CE && running && cmode == CNT_QUAD && !qdm_x4 && rise[0] && !b_ed && !ch_in[1]
			&& cnt != top && !(wr && PADDR == ADDR_CNT) && !cmd_reload
			|=> cnt == $past(cnt) + 16'h0001;
	endproperty
	a_x2: assert property (p_x2) else $error("X2 decode step wrong");

endmodule // timer_capture_compare_quadrature

// *** tb/quad_encoder_model.sv ***
// Encoder and capture-pin model driving the channel inputs
module quad_encoder_model (
	input  wire logic       clk,
	output logic      [2:0] pins
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0] phase;

	initial begin
		pins = 3'h0;
		phase = 2'h0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Gray order of A,B is 00 10 11 01, so only one line moves per step
	task automatic step(input logic fwd);
		phase = fwd ? phase + 2'h1 : phase - 2'h1;
		@(posedge clk);
		pins[0] <= phase[1] ^ phase[0];
		pins[1] <= phase[1];
		repeat (3) @(posedge clk);
	endtask

	// Levels held three cycles so an unfiltered edge is always seen
	task automatic pulse();
		@(posedge clk);
		pins[2] <= 1'b1;
		repeat (3) @(posedge clk);
		pins[2] <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

endmodule // quad_encoder_model

// *** tb/tb.sv ***
// Self-checking bench for the timer compare/capture/quadrature block
module tb
	import tc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [31:0] d;
		logic [31:0] m;
		logic        e;
	} note_s;

	logic           MCLK;
	logic           RSTN;
	logic           CE;
	logic           PSEL;
	logic           PENABLE;
	logic           PWRITE;
	logic [7:0]     PADDR;
	logic [31:0]    PWDATA;
	logic [31:0]    PRDATA;
	logic           PREADY;
	logic           PSLVERR;
	logic [NCH-1:0] pins;
	logic [NCH-1:0] CC_EVT;
	logic [NCH-1:0] CC_OUT;
	note_s          notes[$];
	note_s          nt;
	int             errors;
	int             n_compared;
	int             cycles;
	int             changes;
	int             n;
	int             seed = 32'h7E00;
	logic [15:0]    v [3];
	logic [31:0]    cv;
	logic           prev;

	timer_capture_compare_quadrature dut_u (
		.MCLK(MCLK), .RSTN(RSTN), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
		.PREADY(PREADY), .PSLVERR(PSLVERR), .CC_PIN(pins), .CC_EVT(CC_EVT),
		.CC_OUT(CC_OUT)
	);

	quad_encoder_model enc_u (.clk(MCLK), .pins(pins));

	initial begin
		MCLK = 1'b0;
		forever #25 MCLK = ~MCLK;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Request held until the edge where PREADY is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge MCLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge MCLK);
		PENABLE <= 1'b1;
		@(posedge MCLK);
		while (PREADY !== 1'b1) @(posedge MCLK);
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d,
			input logic [31:0] m = 32'hFFFFFFFF, input logic e = 1'b0);
		notes.push_back('{d & m, m, e});
		apb(1'b0, a, 32'h0);
	endtask

	////////////////////////////////////////////////////////////////////////////
	always @(posedge MCLK) begin
		if (PSEL && PENABLE && PREADY === 1'b1 && PWRITE === 1'b0) begin
			nt = notes.pop_front();
			check("read data", PRDATA & nt.m, nt.d);
			check("slave error", {31'h0, PSLVERR}, {31'h0, nt.e});
		end
	end

	// Ceiling well above the few hundred cycles the tests need
	always @(posedge MCLK) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			report_and_stop();
		end
	end

	initial begin
		RSTN = 1'b0;
		CE = 1'b1;
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 8'h00;
		PWDATA = 32'h0;
		CC_EVT = 3'h0;
		repeat (2) @(posedge MCLK);
		RSTN <= 1'b1;
		rd(ADDR_CTRL, 32'h0);
		rd(ADDR_TOP, 32'h0000FFFF);
		rd(ADDR_CNT, 32'h0);
		rd(ADDR_STATUS, 32'h2);
		rd(8'h18, 32'h0, 32'hFFFFFFFF, 1'b1);
		$display("test reset done");

		wr(ADDR_CTRL, 32'h7);
		wr(ADDR_CMD, 32'h1);
		n = 4 + ($random(seed) & 7);
		repeat (n) enc_u.step(1'b1);
		rd(ADDR_CNT, 32'(n));
		repeat (3) enc_u.step(1'b0);
		rd(ADDR_CNT, 32'(n - 3));
		wr(ADDR_CTRL, 32'h3);
		wr(ADDR_CNT, 32'h0);
		repeat (8) enc_u.step(1'b1);
		rd(ADDR_CNT, 32'h4);
		wr(ADDR_CMD, 32'h2);
		$display("test quadrature done");

		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_TOP, 32'h9);
		wr(ADDR_CNT, 32'h9);
		wr(8'h20, 32'h3C);
		wr(8'h30, 32'h34);
		wr(8'h20, 32'h3E);
		wr(8'h30, 32'h36);
		repeat (2) @(posedge MCLK);
		check("initial outputs", {30'h0, CC_OUT[1:0]}, 32'h2);
		cv = $random(seed) & 7;
		wr(8'h24, cv);
		rd(8'h24, cv);
		wr(ADDR_CMD, 32'h1);
		repeat (3) @(posedge MCLK);
		prev = CC_OUT[0];
		changes = 0;
		repeat (20) begin
			@(posedge MCLK);
			if (CC_OUT[0] !== prev) changes++;
			prev = CC_OUT[0];
		end
		check("toggle count", 32'(changes), 32'h2);
		wr(ADDR_CMD, 32'h2);
		wr(8'h28, 32'h3);
		rd(ADDR_STATUS, 32'h4, 32'h4);
		wr(ADDR_CMD, 32'h1);
		repeat (12) @(posedge MCLK);
		rd(ADDR_STATUS, 32'h0, 32'h4);
		rd(8'h24, 32'h3);
		wr(ADDR_CMD, 32'h2);
		$display("test compare done");

		wr(8'h40, 32'h1);
		for (int i = 0; i < 3; i++) begin
			v[i] = 16'($random(seed));
			wr(ADDR_CNT, {16'h0, v[i]});
			enc_u.pulse();
		end
		rd(ADDR_STATUS, 32'h480, 32'h480);
		rd(ADDR_FLAGS, 32'h0);
		rd(8'h4C, {16'h0, v[0]});
		rd(8'h48, {16'h0, v[2]});
		rd(8'h44, {16'h0, v[0]});
		rd(8'h44, {16'h0, v[2]});
		rd(ADDR_STATUS, 32'h0, 32'h80);
		wr(ADDR_CMD, 32'h1);
		repeat (3) enc_u.pulse();
		rd(ADDR_FLAGS, 32'h4);
		wr(ADDR_FLAGS, 32'h4);
		rd(ADDR_FLAGS, 32'h0);
		$display("test capture done");

		wr(ADDR_CMD, 32'h2);
		wr(8'h20, 32'h2401);
		wr(ADDR_CNT, 32'h55);
		// Filter must settle on the new source before a glitch can test it
		repeat (6) @(posedge MCLK);
		n = 1 + ($random(seed) & 3);
		CC_EVT[0] <= 1'b1;
		repeat (n) @(posedge MCLK);
		CC_EVT[0] <= 1'b0;
		repeat (8) @(posedge MCLK);
		rd(ADDR_STATUS, 32'h0, 32'h20);
		CC_EVT[0] <= 1'b1;
		repeat (8) @(posedge MCLK);
		rd(8'h24, 32'h55);
		rd(ADDR_STATUS, 32'h100, 32'h120);
		$display("test filter done");
		report_and_stop();
	end

endmodule // tb
